// [design/core_regs_pkg.sv]
// Purpose: Constants for the CPU core special registers
// Assumes: 8-bit special-function space, direct addressing only
// Notes:   Offsets are byte addresses in that space
package core_regs_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] frame_top_index_addr    = 8'h81;
	localparam logic [7:0] data_index_low_addr     = 8'h82;
	localparam logic [7:0] data_index_high_addr    = 8'h83;
	localparam logic [7:0] core_state_word_addr    = 8'hd0;
	localparam logic [7:0] main_operand_reg_addr   = 8'he0;
	localparam logic [7:0] second_operand_reg_addr = 8'hf0;
	localparam logic [7:0] sfr_base_addr           = 8'h80;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] frame_top_index_rst = 8'h07;
	localparam logic [7:0] byte_zero_rst       = 8'h00;

	// ------------------------------------------------------------
	// State word field positions
	// ------------------------------------------------------------
	localparam int carry_pos      = 7;
	localparam int half_carry_pos = 6;
	localparam int user_zero_pos  = 5;
	localparam int sel_hi_pos     = 4;
	localparam int sel_lo_pos     = 3;
	localparam int excess_pos     = 2;
	localparam int user_one_pos   = 1;
	localparam int odd_ones_pos   = 0;
	localparam logic [2:0] bit_addr_low_mask = 3'h7;
	localparam logic [7:0] bank_size         = 8'h08;

endpackage : core_regs_pkg

// [design/cpu_core_special_registers.sv]
// Purpose: Core special registers of an 8-bit CPU
// Assumes: One clock, synchronous active-high reset
// Notes:   Datapath updates lose to direct register writes
// Operation
// - Reset loads stack index 0x07 and clears all other registers.
// - A push first increments the stack index, then uses the new value as address.
// - The odd-ones flag is one exactly when the accumulator holds an odd number of ones.
// - The two bank select bits choose one of four eight-register banks for R0 to R7.
// - The state word holds carry, half carry, user 0, sel hi, sel lo, excess, user 1, odd.
// - The 16-bit data index is high byte over low byte and addresses XRAM and flash.
// - Carry is also the one-bit operand and result of Boolean instructions.
// - User flags 0 and 1 are free software bits with no hardware effect.
// - The second operand register is a math operand and otherwise a plain byte.
// - Access is direct in space 80H and up; bit access on addresses ending 0H or 8H.
`timescale 1ns/1ps
module cpu_core_special_registers
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_bit_wr,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic [2:0]  sfr_bit_sel,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic        sfr_bit_wdata,
	output logic      [7:0]  sfr_rdata,
	output logic             sfr_hit,
	input  wire logic        push,
	input  wire logic        pop,
	output logic      [7:0]  stack_addr,
	input  wire logic        acc_wr,
	input  wire logic [7:0]  acc_wdata,
	input  wire logic        second_wr,
	input  wire logic [7:0]  second_wdata,
	input  wire logic        flags_wr,
	input  wire logic        carry_in,
	input  wire logic        half_carry_in,
	input  wire logic        excess_in,
	input  wire logic        bool_wr,
	input  wire logic        bool_in,
	output logic             carry_flag,
	input  wire logic        index_wr,
	input  wire logic [15:0] index_wdata,
	output logic      [15:0] data_index_pair,
	input  wire logic [2:0]  work_reg_sel,
	output logic      [7:0]  work_reg_addr,
	output logic      [7:0]  main_operand_reg,
	output logic      [7:0]  second_operand_reg,
	output logic      [7:0]  core_state_word
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0] frame_top_index;
	logic [7:0] data_index_low;
	logic [7:0] data_index_high;
	logic [7:0] flags;
	logic [7:0] next_frame_top_index;
	logic [7:0] next_data_index_low;
	logic [7:0] next_data_index_high;
	logic [7:0] next_flags;
	logic [7:0] next_main_operand_reg;
	logic [7:0] next_second_operand_reg;
	logic [7:0] byte_wr_val;
	logic       odd_ones_flag;

	sfr_port_if port ();

	assign port.wr        = sfr_wr;
	assign port.bit_wr    = sfr_bit_wr;
	assign port.addr      = sfr_addr;
	assign port.bit_sel   = sfr_bit_sel;
	assign port.wdata     = sfr_wdata;
	assign port.bit_wdata = sfr_bit_wdata;
	assign sfr_rdata      = port.rdata;
	assign sfr_hit        = port.hit;

	sfr_decode u_decode
	(
		.port               (port),
		.frame_top_index    (frame_top_index),
		.data_index_low     (data_index_low),
		.data_index_high    (data_index_high),
		.core_state_word    (core_state_word),
		.main_operand_reg   (main_operand_reg),
		.second_operand_reg (second_operand_reg)
	);

	// ------------------------------------------------------------
	// Derived outputs
	// ------------------------------------------------------------
	// odd-ones from accumulator
	assign odd_ones_flag = ^main_operand_reg;
	assign core_state_word = {flags[7:1], odd_ones_flag};
	assign carry_flag = flags[core_regs_pkg::carry_pos];
	assign data_index_pair = {data_index_high, data_index_low};
	assign work_reg_addr = 8'({flags[core_regs_pkg::sel_hi_pos],
		flags[core_regs_pkg::sel_lo_pos], work_reg_sel});
	assign stack_addr = push ? 8'(frame_top_index + 8'h01) : frame_top_index;

	// ------------------------------------------------------------
	// Next values
	// ------------------------------------------------------------
	function automatic logic [7:0] wr_byte(input logic [7:0] cur, input logic [7:0] a);
		logic [7:0] v;
		v = cur;
		if (port.hit && sfr_addr == a && sfr_wr)
		begin
			v = sfr_wdata;
		end
		else if (port.bit_ok && sfr_addr == a && sfr_bit_wr)
		begin
			v[sfr_bit_sel] = sfr_bit_wdata;
		end
		return v;
	endfunction : wr_byte

	always_comb
	begin
		byte_wr_val = 8'h00;
		next_frame_top_index = frame_top_index;
		if (push)
		begin
			next_frame_top_index = 8'(frame_top_index + 8'h01);
		end
		else if (pop)
		begin
			next_frame_top_index = 8'(frame_top_index - 8'h01);
		end
		next_frame_top_index = wr_byte(next_frame_top_index,
			core_regs_pkg::frame_top_index_addr);
		next_data_index_low  = index_wr ? index_wdata[7:0] : data_index_low;
		next_data_index_high = index_wr ? index_wdata[15:8] : data_index_high;
		next_data_index_low  = wr_byte(next_data_index_low,
			core_regs_pkg::data_index_low_addr);
		next_data_index_high = wr_byte(next_data_index_high,
			core_regs_pkg::data_index_high_addr);
		next_main_operand_reg = acc_wr ? acc_wdata : main_operand_reg;
		next_main_operand_reg = wr_byte(next_main_operand_reg,
			core_regs_pkg::main_operand_reg_addr);
		next_second_operand_reg = second_wr ? second_wdata : second_operand_reg;
		next_second_operand_reg = wr_byte(next_second_operand_reg,
			core_regs_pkg::second_operand_reg_addr);
		next_flags = flags;
		if (flags_wr)
		begin
			next_flags[core_regs_pkg::carry_pos]      = carry_in;
			next_flags[core_regs_pkg::half_carry_pos] = half_carry_in;
			next_flags[core_regs_pkg::excess_pos]     = excess_in;
		end
		if (bool_wr)
		begin
			next_flags[core_regs_pkg::carry_pos] = bool_in;
		end
		byte_wr_val = wr_byte(core_state_word, core_regs_pkg::core_state_word_addr);
		next_flags = (port.hit && sfr_addr == core_regs_pkg::core_state_word_addr
			&& (sfr_wr || sfr_bit_wr)) ? byte_wr_val : next_flags;
		next_flags[core_regs_pkg::odd_ones_pos] = 1'b0;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			frame_top_index    <= core_regs_pkg::frame_top_index_rst;
			data_index_low     <= core_regs_pkg::byte_zero_rst;
			data_index_high    <= core_regs_pkg::byte_zero_rst;
			flags              <= core_regs_pkg::byte_zero_rst;
			main_operand_reg   <= core_regs_pkg::byte_zero_rst;
			second_operand_reg <= core_regs_pkg::byte_zero_rst;
		end
		else
		begin
			frame_top_index    <= next_frame_top_index;
			data_index_low     <= next_data_index_low;
			data_index_high    <= next_data_index_high;
			flags              <= next_flags;
			main_operand_reg   <= next_main_operand_reg;
			second_operand_reg <= next_second_operand_reg;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	reset_stack_a: assert property (@(posedge clk) disable iff (1'b0)
		rst |=> frame_top_index == 8'h07 && main_operand_reg == 8'h00)
		else $error("stack index not 0x07 after reset");
	push_incr_a: assert property (push && !sfr_wr && !sfr_bit_wr
		|-> stack_addr == 8'(frame_top_index + 8'h01) ##1 frame_top_index == $past(stack_addr))
		else $error("push did not pre-increment");
	odd_ones_a: assert property (sfr_addr == 8'hd0 |-> sfr_rdata[0] == ^main_operand_reg)
		else $error("odd-ones flag wrong");
	acc_same_cycle_a: assert property (acc_wr && !sfr_wr && !sfr_bit_wr
		|=> core_state_word[0] == ^$past(acc_wdata))
		else $error("odd-ones flag lagged accumulator");
	bank_select_a: assert property (work_reg_addr ==
		{3'h0, core_state_word[4:3], work_reg_sel})
		else $error("bank address wrong");
	index_pair_a: assert property (index_wr && !sfr_wr && !sfr_bit_wr
		|=> data_index_pair == $past(index_wdata))
		else $error("index pair not loaded");
	bool_carry_a: assert property (bool_wr && !sfr_wr && !sfr_bit_wr
		|=> carry_flag == $past(bool_in) && core_state_word[7] == carry_flag)
		else $error("Boolean carry not stored");
	user_flags_a: assert property (!sfr_wr && !sfr_bit_wr
		|=> $stable(core_state_word[5]) && $stable(core_state_word[1]))
		else $error("user flag changed by hardware");
	second_reg_a: assert property (second_wr && !sfr_wr && !sfr_bit_wr
		|=> second_operand_reg == $past(second_wdata))
		else $error("second operand not loaded");
	low_space_a: assert property (sfr_addr < 8'h80 |-> !sfr_hit)
		else $error("low address hit");
	bit_row_a: assert property (sfr_bit_wr && !sfr_wr && sfr_addr == 8'h81 && !push && !pop
		|=> $stable(frame_top_index))
		else $error("bit write on non-bit row");
	state_bits_a: assert property (flags_wr && !bool_wr && !sfr_wr && !sfr_bit_wr
		|=> core_state_word[7] == $past(carry_in) && core_state_word[6] == $past(half_carry_in)
		&& core_state_word[2] == $past(excess_in))
		else $error("state word layout wrong");

	push_c:  cover property (push ##1 push);
	accw_c:  cover property (sfr_wr && sfr_addr == 8'he0);
	bitw_c:  cover property (sfr_bit_wr && sfr_addr == 8'hd0);
	bank_c:  cover property (core_state_word[4:3] == 2'h3);
endmodule : cpu_core_special_registers

// [design/sfr_decode.sv]
// Purpose: Address decode and read mux for the core registers
// Assumes: Direct addressing of the special-function space
// Notes:   Reads are combinational; unmapped reads give zero
`timescale 1ns/1ps
module sfr_decode
(
	sfr_port_if.decode         port,
	input  wire logic [7:0]    frame_top_index,
	input  wire logic [7:0]    data_index_low,
	input  wire logic [7:0]    data_index_high,
	input  wire logic [7:0]    core_state_word,
	input  wire logic [7:0]    main_operand_reg,
	input  wire logic [7:0]    second_operand_reg
);
	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	always_comb
	begin
		port.hit   = 1'b1;
		port.rdata = core_regs_pkg::byte_zero_rst;
		case (port.addr)
			core_regs_pkg::frame_top_index_addr:    port.rdata = frame_top_index;
			core_regs_pkg::data_index_low_addr:     port.rdata = data_index_low;
			core_regs_pkg::data_index_high_addr:    port.rdata = data_index_high;
			core_regs_pkg::core_state_word_addr:    port.rdata = core_state_word;
			core_regs_pkg::main_operand_reg_addr:   port.rdata = main_operand_reg;
			core_regs_pkg::second_operand_reg_addr: port.rdata = second_operand_reg;
			default:                                port.hit   = 1'b0;
		endcase
		if (port.addr < core_regs_pkg::sfr_base_addr)
		begin
			port.hit = 1'b0;
		end
		port.bit_ok = port.hit && (port.addr[2:0] == 3'h0);
	end
endmodule : sfr_decode

// [design/sfr_port_if.sv]
// Purpose: Special-function register access channel
// Assumes: Single clock, one access per cycle
// Notes:   Carries direct byte and bit accesses
`timescale 1ns/1ps
interface sfr_port_if;
	logic       wr;
	logic       bit_wr;
	logic [7:0] addr;
	logic [2:0] bit_sel;
	logic [7:0] wdata;
	logic       bit_wdata;
	logic       hit;
	logic       bit_ok;
	logic [7:0] rdata;
	modport host
	(
		output wr, bit_wr, addr, bit_sel, wdata, bit_wdata,
		input  hit, bit_ok, rdata
	);
	modport decode
	(
		input  wr, bit_wr, addr, bit_sel, wdata, bit_wdata,
		output hit, bit_ok, rdata
	);
endinterface : sfr_port_if

// [sim/cpu_core_special_registers_tb.sv]
// Purpose: Self-checking bench for the core registers
// Assumes: Datapath driven through the model
// Notes:   Reads are sampled 1 ns after the edge
`timescale 1ns/1ps
module cpu_core_special_registers_tb;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        sfr_wr = 1'h0;
	logic        sfr_bit_wr = 1'h0;
	logic [7:0]  sfr_addr = 8'h00;
	logic [2:0]  sfr_bit_sel = 3'h0;
	logic [7:0]  sfr_wdata = 8'h00;
	logic        sfr_bit_wdata = 1'h0;
	logic [2:0]  work_reg_sel = 3'h5;
	logic [2:0]  op = 3'h0;
	logic [15:0] arg = 16'h0000;
	logic [7:0]  sfr_rdata, stack_addr, work_reg_addr;
	logic [7:0]  main_operand_reg, second_operand_reg, core_state_word, v, e;
	logic        sfr_hit, carry_flag, push, pop, acc_wr, second_wr, flags_wr, bool_wr, index_wr;
	logic [15:0] data_index_pair, data;
	logic [7:0]  zaddr [5] = '{8'h82, 8'h83, 8'hd0, 8'he0, 8'hf0};
	logic [7:0]  vals [4] = '{8'h07, 8'h03, 8'h80, 8'hff};
	int          fails = 0;
	int          n_tests = 0;
	int          cyc = 0;
	always #12.5 clk = ~clk;
	cpu_core_special_registers cpu_core_special_registers_i
	(
		.clk, .rst, .sfr_wr, .sfr_bit_wr, .sfr_addr, .sfr_bit_sel, .sfr_wdata, .sfr_bit_wdata,
		.sfr_rdata, .sfr_hit, .push, .pop, .stack_addr, .acc_wr, .acc_wdata(data[7:0]),
		.second_wr, .second_wdata(data[7:0]), .flags_wr, .carry_in(data[2]),
		.half_carry_in(data[1]), .excess_in(data[0]), .bool_wr, .bool_in(data[0]),
		.carry_flag, .index_wr, .index_wdata(data), .data_index_pair, .work_reg_sel,
		.work_reg_addr, .main_operand_reg, .second_operand_reg, .core_state_word
	);
	datapath_model datapath_model_i
	(
		.op, .arg, .push, .pop, .acc_wr, .second_wr, .flags_wr, .bool_wr, .index_wr, .data
	);
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_wr <= !b;
		sfr_bit_wr <= b;
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_bit_sel <= d[2:0];
		sfr_bit_wdata <= d[3];
		@(posedge clk);
		sfr_wr <= 1'h0;
		sfr_bit_wr <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk);
		sfr_addr <= a;
		#1;
		chk(sfr_rdata, x);
	endtask : rd
	task automatic dp(input logic [2:0] o, input logic [15:0] a);
		@(posedge clk);
		op <= o;
		arg <= a;
		@(posedge clk);
		op <= 3'h0;
	endtask : dp
	task automatic end_sim;
		if (fails == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			fails++;
			end_sim();
		end
	end
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		rd(8'h81, 8'h07);
		for (int i = 0; i < 5; i++)
			rd(zaddr[i], 8'h00);
		rd(8'h20, 8'h00);
		chk(sfr_hit, 1'h0);
		wr(1'h1, 8'h83, 8'h0f);
		rd(8'h83, 8'h00);
		wr(1'h1, 8'h81, 8'h0f);
		rd(8'h81, 8'h07);
		for (int i = 0; i < 4; i++)
		begin
			v = vals[i];
			if (i % 2 == 1)
				dp(3'h3, {8'h00, v});
			else
				wr(1'h0, 8'he0, v);
			rd(8'he0, v);
			rd(8'hd0, {7'h00, ^v});
		end
		wr(1'h0, 8'hd0, 8'h01);
		rd(8'hd0, 8'h00);
		wr(1'h1, 8'he0, 8'h00);
		rd(8'hd0, 8'h01);
		for (int b = 0; b < 4; b++)
		begin
			wr(1'h0, 8'hd0, {3'h0, b[1:0], 3'h0});
			work_reg_sel <= b[2:0] ^ 3'h6;
			rd(8'hd0, {3'h0, b[1:0], 3'h1});
			chk(work_reg_addr, {3'h0, b[1:0], b[2:0] ^ 3'h6});
		end
		wr(1'h0, 8'hd0, 8'hfe);
		e = 8'hff;
		rd(8'hd0, e);
		chk(carry_flag, 1'h1);
		for (int p = 7; p > 0; p--)
		begin
			wr(1'h1, 8'hd0, {5'h00, p[2:0]});
			e[p] = 1'h0;
			rd(8'hd0, e);
		end
		wr(1'h0, 8'hd0, 8'h22);
		dp(3'h5, 16'h0005);
		rd(8'hd0, 8'ha7);
		dp(3'h5, 16'h0002);
		rd(8'hd0, 8'h63);
		dp(3'h6, 16'h0001);
		rd(8'hd0, 8'he3);
		dp(3'h6, 16'h0000);
		rd(8'hd0, 8'h63);
		chk(carry_flag, 1'h0);
		foreach (zaddr[i])
			if (i < 2)
			begin
				v = (i == 0) ? 8'h07 : 8'hff;
				wr(1'h0, 8'h81, v);
				@(posedge clk);
				op <= 3'h1;
				#1;
				chk(stack_addr, 8'(v + 8'h01));
				@(posedge clk);
				op <= 3'h0;
				rd(8'h81, v + 8'h01);
				dp(3'h2, 16'h0000);
				rd(8'h81, v);
			end
		wr(1'h0, 8'h83, 8'h12);
		wr(1'h0, 8'h82, 8'h34);
		rd(8'h82, 8'h34);
		chk(data_index_pair, 16'h1234);
		dp(3'h7, 16'habcd);
		rd(8'h83, 8'hab);
		rd(8'h82, 8'hcd);
		wr(1'h0, 8'hf0, 8'h5a);
		rd(8'hf0, 8'h5a);
		dp(3'h4, 16'h00c3);
		rd(8'hf0, 8'hc3);
		@(posedge clk);
		rst <= 1'h1;
		@(posedge clk);
		rst <= 1'h0;
		rd(8'h81, 8'h07);
		for (int i = 0; i < 5; i++)
			rd(zaddr[i], 8'h00);
		end_sim();
	end
endmodule : cpu_core_special_registers_tb

// [sim/datapath_model.sv]
// Purpose: Datapath side model for the core registers
// Assumes: One command per cycle from the bench
// Notes:   Commands decode to one-cycle strobes
`timescale 1ns/1ps
module datapath_model
(
	input  wire logic [2:0]  op,
	input  wire logic [15:0] arg,
	output logic             push,
	output logic             pop,
	output logic             acc_wr,
	output logic             second_wr,
	output logic             flags_wr,
	output logic             bool_wr,
	output logic             index_wr,
	output logic [15:0]      data
);
	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	always_comb
	begin
		push = op == 3'h1;
		pop = op == 3'h2;
		acc_wr = op == 3'h3;
		second_wr = op == 3'h4;
		flags_wr = op == 3'h5;
		bool_wr = op == 3'h6;
		index_wr = op == 3'h7;
		data = arg;
	end
endmodule : datapath_model
